/* bmw_defines.svh */
// offsets, field positions, reset values and read-only patterns of the memory window registers
// Functional notes
// RULE_01: internal-bus error flags (bits 15:11 and 8) always read zero.
// RULE_02: select-timing field, bits 10:9 of internal bus status, always reads 00.
// RULE_03: back-to-back and high-speed capability bits 7 and 5 read zero.
// RULE_04: reserved status bits 6 and 4:0 read zero; whole status register reads zero.
// RULE_05: writable memory bottom field 15:4 gives address 31:20, low 20 bits zero.
// RULE_06: writable memory top field 15:4 gives address 31:20, low 20 bits ones.
// RULE_07: memory bottom and top decide downstream forwarding of memory transactions.
// RULE_08: bits 3:0 of memory bottom and top registers are read-only zero.
// RULE_09: writable prefetch bottom field 15:4, low bits zero, upper half elsewhere.
// RULE_10: prefetch bottom bits 3:0 read-only one, advertising 64-bit addressing.
// RULE_11: memory bottom resets to zero and keeps whatever software writes.
// RULE_12: separate writable 32-bit prefetch bottom upper half at offset 28h.
// RULE_13: windows are inclusive at both the expanded bottom and expanded top.
// RULE_14: prefetch window compared over 64 bits using the upper register.
`ifndef BMW_DEFINES_SVH
`define BMW_DEFINES_SVH
`define BMW_OFF_STATUS 8'h1e
`define BMW_OFF_MEM_BOT 8'h20
`define BMW_OFF_MEM_TOP 8'h22
`define BMW_OFF_PF_BOT 8'h24
`define BMW_OFF_PF_UPPER 8'h28
`define BMW_STATUS_RESET 16'h0000
`define BMW_MEM_BOT_RESET 12'h000
`define BMW_MEM_TOP_RESET 12'h000
`define BMW_PF_BOT_RESET 12'h000
`define BMW_PF_UPPER_RESET 32'h0000_0000
`define BMW_MEM_TYPE 4'h0
`define BMW_PF_TYPE 4'h1
`define BMW_LOW_ZERO 20'h0_0000
`define BMW_LOW_ONES 20'hf_ffff
`endif

/* bmw_pkg.sv */
// types shared by the memory window register bank
package bmw_pkg;
  // one configuration access, dword aligned, byte enables per lane
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bmw_cfg_req_t;

  // one memory transaction address offered for a window check
  typedef struct packed {
    logic valid;
    logic [63:0] addr;
  } bmw_lookup_t;

  // whole state of the bank
  typedef struct packed {
    logic [11:0] mem_bot;
    logic [11:0] mem_top;
    logic [11:0] pf_bot;
    logic [31:0] pf_upper;
    logic [31:0] rdata;
    logic rvalid;
    logic mem_hit;
    logic pf_hit;
    logic hit_valid;
  } bmw_state_t;
endpackage

/* bmw_regs.sv */
// memory window register bank with downstream forwarding decision
`timescale 1ns/10ps
`default_nettype none
`include "bmw_defines.svh"
module bmw_regs (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  // configuration access
  input wire bmw_pkg::bmw_cfg_req_t CFG_REQ_I,
  output logic [31:0] CFG_RDATA_O,
  output logic CFG_RVALID_O,
  // window lookup
  input wire bmw_pkg::bmw_lookup_t LOOKUP_I,
  input wire logic [63:0] PF_TOP_I,
  output logic MEM_HIT_O,
  output logic PF_HIT_O,
  output logic HIT_VALID_O
);
  import bmw_pkg::*;

  bmw_state_t st_ff;
  bmw_state_t nxt_st;
  logic [31:0] merged;
  logic [31:0] cur_word;
  logic [31:0] mem_lo;
  logic [31:0] mem_hi;
  logic [63:0] pf_lo;

  // true when the access hits the dword holding the given offset
  function automatic logic dword_hit(input logic [7:0] a, input logic [7:0] off);
    dword_hit = (a[7:2] == off[7:2]);
  endfunction

  // byte-enable merge of write data over the current dword
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  // expanded window edges
  // RULE_05 bottom low bits zero
  assign mem_lo = {st_ff.mem_bot, `BMW_LOW_ZERO};
  // RULE_06 top low bits ones
  assign mem_hi = {st_ff.mem_top, `BMW_LOW_ONES};
  // RULE_14 64-bit prefetch bottom
  assign pf_lo = {st_ff.pf_upper, st_ff.pf_bot, `BMW_LOW_ZERO};

  // read view of the addressed dword; unimplemented halves read zero
  always_comb begin
    cur_word = 32'h0000_0000;
    if (dword_hit(CFG_REQ_I.addr, `BMW_OFF_STATUS)) begin
      // RULE_01 RULE_02 RULE_03 RULE_04 status hardwired zero
      cur_word = {`BMW_STATUS_RESET, 16'h0000};
    end else if (dword_hit(CFG_REQ_I.addr, `BMW_OFF_MEM_BOT)) begin
      // RULE_08 low nibbles read zero
      cur_word = {st_ff.mem_top, `BMW_MEM_TYPE, st_ff.mem_bot, `BMW_MEM_TYPE};
    end else if (dword_hit(CFG_REQ_I.addr, `BMW_OFF_PF_BOT)) begin
      // RULE_10 wide address indicator
      cur_word = {16'h0000, st_ff.pf_bot, `BMW_PF_TYPE};
    end else if (dword_hit(CFG_REQ_I.addr, `BMW_OFF_PF_UPPER)) begin
      cur_word = st_ff.pf_upper;
    end
  end

  assign merged = be_merge(cur_word, CFG_REQ_I.wdata, CFG_REQ_I.be);

  // next state: writes only touch writable fields, read-only bits are rebuilt
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = CFG_REQ_I.rd;
    nxt_st.rdata = CFG_REQ_I.rd ? cur_word : st_ff.rdata;
    if (CFG_REQ_I.wr) begin
      if (dword_hit(CFG_REQ_I.addr, `BMW_OFF_MEM_BOT)) begin
        // RULE_11 bottom keeps written value
        nxt_st.mem_bot = merged[15:4];
        // RULE_06 writable top field
        nxt_st.mem_top = merged[31:20];
      end
      if (dword_hit(CFG_REQ_I.addr, `BMW_OFF_PF_BOT)) begin
        // RULE_09 writable prefetch bottom
        nxt_st.pf_bot = merged[15:4];
      end
      if (dword_hit(CFG_REQ_I.addr, `BMW_OFF_PF_UPPER)) begin
        // RULE_12 upper half register
        nxt_st.pf_upper = merged;
      end
    end
    // the decision uses the settings before a same-cycle write lands
    nxt_st.hit_valid = LOOKUP_I.valid;
    // RULE_07 RULE_13 inclusive 32-bit memory window
    nxt_st.mem_hit = LOOKUP_I.valid && (LOOKUP_I.addr[63:32] == 32'h0000_0000) &&
                     (LOOKUP_I.addr[31:0] >= mem_lo) && (LOOKUP_I.addr[31:0] <= mem_hi);
    // RULE_13 RULE_14 inclusive 64-bit prefetch window
    nxt_st.pf_hit = LOOKUP_I.valid && (LOOKUP_I.addr >= pf_lo) && (LOOKUP_I.addr <= PF_TOP_I);
    if (SRST_I) begin
      // RULE_11 reset values
      nxt_st.mem_bot = `BMW_MEM_BOT_RESET;
      nxt_st.mem_top = `BMW_MEM_TOP_RESET;
      nxt_st.pf_bot = `BMW_PF_BOT_RESET;
      nxt_st.pf_upper = `BMW_PF_UPPER_RESET;
      nxt_st.rdata = 32'h0000_0000;
      nxt_st.rvalid = 1'b0;
      nxt_st.mem_hit = 1'b0;
      nxt_st.pf_hit = 1'b0;
      nxt_st.hit_valid = 1'b0;
    end
  end

  // single state register
  always_ff @(posedge CLOCK_I) begin
    st_ff <= nxt_st;
  end

  // outputs straight from the state register
  assign CFG_RDATA_O = st_ff.rdata;
  assign CFG_RVALID_O = st_ff.rvalid;
  assign MEM_HIT_O = st_ff.mem_hit;
  assign PF_HIT_O = st_ff.pf_hit;
  assign HIT_VALID_O = st_ff.hit_valid;

  // status dword upper half always zero
  a_status_reads_zero: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_04
    CFG_REQ_I.rd && dword_hit(CFG_REQ_I.addr, `BMW_OFF_STATUS) |=>
    CFG_RVALID_O && (CFG_RDATA_O[31:16] == 16'h0000))
    else $error("internal bus status read nonzero");

  a_mem_low_zero: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_08
    CFG_REQ_I.rd && dword_hit(CFG_REQ_I.addr, `BMW_OFF_MEM_BOT) |=>
    (CFG_RDATA_O[3:0] == 4'h0) && (CFG_RDATA_O[19:16] == 4'h0))
    else $error("memory window low nibble not zero");

  a_pf_type_one: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_10
    CFG_REQ_I.rd && dword_hit(CFG_REQ_I.addr, `BMW_OFF_PF_BOT) |=>
    CFG_RDATA_O[3:0] == 4'h1)
    else $error("prefetch type field not one");

  a_mem_bot_write: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_11
    CFG_REQ_I.wr && (CFG_REQ_I.be[1:0] == 2'h3) && dword_hit(CFG_REQ_I.addr, `BMW_OFF_MEM_BOT)
    |=> st_ff.mem_bot == $past(CFG_REQ_I.wdata[15:4]))
    else $error("memory bottom write lost");

  a_pf_upper_write: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_12
    CFG_REQ_I.wr && (CFG_REQ_I.be == 4'hf) && dword_hit(CFG_REQ_I.addr, `BMW_OFF_PF_UPPER)
    |=> st_ff.pf_upper == $past(CFG_REQ_I.wdata))
    else $error("prefetch upper write lost");

  a_reset_clears: assert property (@(posedge CLOCK_I) // RULE_11
    SRST_I |=> (st_ff.mem_bot == 12'h000) && (st_ff.pf_upper == 32'h0000_0000) &&
    !CFG_RVALID_O && !MEM_HIT_O)
    else $error("reset values wrong");

  a_mem_bottom_edge: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_13
    LOOKUP_I.valid && (LOOKUP_I.addr == {32'h0000_0000, mem_lo}) && (mem_lo <= mem_hi)
    |=> MEM_HIT_O && HIT_VALID_O)
    else $error("memory bottom edge not forwarded");

  a_mem_top_edge: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_07
    LOOKUP_I.valid && (LOOKUP_I.addr == {32'h0000_0000, mem_hi}) && (mem_lo <= mem_hi)
    |=> MEM_HIT_O)
    else $error("memory top edge not forwarded");

  a_mem_below_miss: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_05
    LOOKUP_I.valid && (LOOKUP_I.addr < {32'h0000_0000, mem_lo}) |=> !MEM_HIT_O)
    else $error("address below memory bottom forwarded");

  a_pf_wide_miss: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_14
    LOOKUP_I.valid && (LOOKUP_I.addr < pf_lo) |=> HIT_VALID_O && !PF_HIT_O)
    else $error("address below prefetch bottom forwarded");

  // error, select-timing and capability status fields each checked on their own so a fault names the field
  a_error_flags_zero: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_01
    CFG_REQ_I.rd && dword_hit(CFG_REQ_I.addr, `BMW_OFF_STATUS) |=>
    (CFG_RDATA_O[31:27] == 5'h00) && !CFG_RDATA_O[24])
    else $error("internal bus error flag set");

  a_select_timing_zero: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_02
    CFG_REQ_I.rd && dword_hit(CFG_REQ_I.addr, `BMW_OFF_STATUS) |=>
    CFG_RDATA_O[26:25] == 2'h0)
    else $error("select timing field not zero");

  a_capability_zero: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_03
    CFG_REQ_I.rd && dword_hit(CFG_REQ_I.addr, `BMW_OFF_STATUS) |=>
    !CFG_RDATA_O[23] && !CFG_RDATA_O[21])
    else $error("capability bit set");

  // a full write of the upper half must land in the top field
  a_mem_top_write: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_06
    CFG_REQ_I.wr && (CFG_REQ_I.be[3:2] == 2'h3) && dword_hit(CFG_REQ_I.addr, `BMW_OFF_MEM_BOT)
    |=> st_ff.mem_top == $past(CFG_REQ_I.wdata[31:20]))
    else $error("memory top write lost");

  a_pf_bot_write: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_09
    CFG_REQ_I.wr && (CFG_REQ_I.be[1:0] == 2'h3) && dword_hit(CFG_REQ_I.addr, `BMW_OFF_PF_BOT)
    |=> st_ff.pf_bot == $past(CFG_REQ_I.wdata[15:4]))
    else $error("prefetch bottom write lost");

  // hits only stand in the cycle after a lookup, so a stale hit cannot forward
  a_idle_no_hit: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_07
    !LOOKUP_I.valid |=> !HIT_VALID_O && !MEM_HIT_O && !PF_HIT_O)
    else $error("hit shown without lookup");

  a_mem_above_miss: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_06
    LOOKUP_I.valid && (LOOKUP_I.addr > {32'h0000_0000, mem_hi}) |=> !MEM_HIT_O)
    else $error("address above memory top forwarded");

  a_pf_above_miss: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_13
    LOOKUP_I.valid && (LOOKUP_I.addr > PF_TOP_I) |=> HIT_VALID_O && !PF_HIT_O)
    else $error("address above prefetch top forwarded");

  // the memory window is 32-bit only, so high addresses never hit it
  a_mem_high_miss: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_05
    LOOKUP_I.valid && (LOOKUP_I.addr[63:32] != 32'h0000_0000) |=> !MEM_HIT_O)
    else $error("high address hit memory window");

  // a read answers in exactly the next cycle; reads during reset are not taken
  a_read_answer: assert property (@(posedge CLOCK_I) disable iff (SRST_I) // RULE_11
    CFG_RVALID_O == ($past(CFG_REQ_I.rd) && !$past(SRST_I)))
    else $error("read answer out of step");
endmodule
`default_nettype wire

/* bmw_tb.sv */
// self-checking testbench for the memory window register bank
`timescale 1ns/10ps
`default_nettype none
module tb;
  import bmw_pkg::*;
  logic clk;
  logic srst;
  bmw_cfg_req_t req;
  bmw_lookup_t lkp;
  logic [63:0] pf_top;
  logic [31:0] rdata;
  logic rvalid;
  logic mem_hit;
  logic pf_hit;
  logic hit_valid;
  int n_mismatch;
  int total_checks;

  // device under test, every input driven by the bench
  bmw_regs dut_u (.CLOCK_I(clk), .SRST_I(srst), .CFG_REQ_I(req), .CFG_RDATA_O(rdata),
    .CFG_RVALID_O(rvalid), .LOOKUP_I(lkp), .PF_TOP_I(pf_top), .MEM_HIT_O(mem_hit),
    .PF_HIT_O(pf_hit), .HIT_VALID_O(hit_valid));

  // 25 mhz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe; no answer comes back
  task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk) req <= '{rd: 1'b0, wr: 1'b1, addr: a, be: be, wdata: d};
    @(posedge clk) req <= '0;
  endtask

  // read strobe; the answer must stand in exactly the next cycle
  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk) req <= '{rd: 1'b1, wr: 1'b0, addr: a, be: 4'h0, wdata: 32'h0};
    @(posedge clk) req <= '0;
    #1;
    chk_bit(rvalid, 1'b1);
    chk_data(rdata, exp);
  endtask

  // hits are looked at in the single cycle they stand
  task automatic look(input logic [63:0] a, input logic em, input logic ep);
    @(posedge clk) lkp <= '{valid: 1'b1, addr: a};
    @(posedge clk) lkp <= '0;
    #1;
    chk_bit(hit_valid, 1'b1);
    chk_bit(mem_hit, em);
    chk_bit(pf_hit, ep);
  endtask

  // watchdog: the tests need fewer than a hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    srst = 1'b1;
    req = '0;
    lkp = '0;
    pf_top = 64'h0000_0001_2fff_ffff;
    n_mismatch = 0;
    total_checks = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    cfg_rd(8'h1c, 32'h0000_0000);
    cfg_rd(8'h20, 32'h0000_0000);
    cfg_rd(8'h24, 32'h0000_0001);
    cfg_rd(8'h28, 32'h0000_0000);
    $display("test reset values done");
    cfg_wr(8'h1c, 4'hf, 32'hffff_ffff);
    cfg_rd(8'h1c, 32'h0000_0000);
    cfg_wr(8'h20, 4'hf, 32'hffff_ffff);
    cfg_rd(8'h20, 32'hfff0_fff0);
    cfg_wr(8'h24, 4'hf, 32'hffff_ffff);
    cfg_rd(8'h24, 32'h0000_fff1);
    cfg_wr(8'h28, 4'hf, 32'hdead_beef);
    cfg_rd(8'h28, 32'hdead_beef);
    cfg_wr(8'h2c, 4'hf, 32'hffff_ffff);
    cfg_rd(8'h2c, 32'h0000_0000);
    cfg_rd(8'h28, 32'hdead_beef);
    cfg_wr(8'h1e, 4'hc, 32'h0600_0000);
    cfg_rd(8'h1e, 32'h0000_0000);
    cfg_wr(8'h1e, 4'h4, 32'h00a0_0000);
    cfg_rd(8'h1f, 32'h0000_0000);
    $display("test read-only masks done");
    // memory window 1000_0000..1fff_ffff, prefetch 1_2000_0000..PF_TOP
    cfg_wr(8'h20, 4'hf, 32'h1ff0_1000);
    cfg_wr(8'h24, 4'hf, 32'h0000_2000);
    cfg_wr(8'h28, 4'hf, 32'h0000_0001);
    cfg_rd(8'h20, 32'h1ff0_1000);
    look(64'h0000_0000_1000_0000, 1'b1, 1'b0);
    look(64'h0000_0000_0fff_ffff, 1'b0, 1'b0);
    look(64'h0000_0000_1fff_ffff, 1'b1, 1'b0);
    look(64'h0000_0000_2000_0000, 1'b0, 1'b0);
    look(64'h0000_0001_1000_0000, 1'b0, 1'b0);
    look(64'h0000_0001_2000_0000, 1'b0, 1'b1);
    look(64'h0000_0001_1fff_ffff, 1'b0, 1'b0);
    look(64'h0000_0001_2fff_ffff, 1'b0, 1'b1);
    look(64'h0000_0001_3000_0000, 1'b0, 1'b0);
    look(64'h0000_0000_2000_0000, 1'b0, 1'b0);
    $display("test window lookups done");
    // only lane 2 changes: top field low nibble, type bits stay zero
    cfg_wr(8'h20, 4'h4, 32'h55ab_5555);
    cfg_rd(8'h20, 32'h1fa0_1000);
    // a second reset in mid-run restores the defaults
    @(posedge clk) srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    cfg_rd(8'h20, 32'h0000_0000);
    cfg_rd(8'h24, 32'h0000_0001);
    $display("test lanes and reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
